// *** src/epm_port.sv ***
// Purpose: Pin-level EPROM programming and verify port with AHB-Lite status registers
// Assumes: Pins asynchronous to hclk, programmer holds levels static around strobes
// Notes:   Programming happens on the falling edge of the program strobe
`timescale 1ns/10ps
`include "epm_consts.svh"
module epm_port #(
   parameter int       ADDR_W = `EPM_ADDR_W,
   parameter bit [7:0] SIG0   = 8'hA5, // Arbitrary identification value
   parameter bit [7:0] SIG1   = 8'h3C, // Arbitrary identification value
   parameter bit [7:0] SIG2   = 8'h0F  // Arbitrary identification value
) (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   // Programming control pins
   input  wire logic        reset_pin,
   input  wire logic        fetch_strobe_n,
   input  wire logic        latch_pulse_program_strobe,
   input  wire logic        prog_voltage_high,
   input  wire logic        ext_access_high,
   input  wire logic        mode_select_a,
   input  wire logic        mode_select_b,
   input  wire logic        mode_select_c,
   input  wire logic        mode_select_d,
   input  wire logic        mode_select_e,
   // Address and data pins
   input  wire logic [7:0]  low_address_pins,
   input  wire logic [5:0]  high_address_pins,
   input  wire logic [7:0]  code_byte_pins_in,
   output logic [7:0]       code_byte_pins_out,
   output logic             code_byte_pins_oe
);
   if (ADDR_W != `EPM_ADDR_W) begin : g_check
      $error("epm_port supports a 14-bit address only");
   end

   epm_pkg::epm_state_type s;
   epm_pkg::epm_state_type next_s;

   epm_mem_if #(.AW(ADDR_W))      code_if ();
   epm_mem_if #(.AW(`EPM_ENC_W))  enc_if ();

   epm_mem #(.AW(ADDR_W)) u_code (
      .hclk (hclk),
      .port (code_if)
   );

   epm_mem #(.AW(`EPM_ENC_W)) u_enc (
      .hclk (hclk),
      .port (enc_if)
   );

   // Mode from static pin levels only
   function automatic epm_pkg::epm_mode_type decode_mode(input logic [`EPM_PIN_W-1:0] p);
      logic [4:0] ms;
      epm_pkg::epm_mode_type m;
      ms = p[`EPM_P_MSA:`EPM_P_MSE];
      m  = epm_pkg::EPM_IDLE;
      if (p[`EPM_P_RST] && !p[`EPM_P_FETCH]) begin
         if (p[`EPM_P_VPP]) begin
            unique case (ms)
               5'h0F: m = epm_pkg::EPM_PROG_CODE;
               5'h0D: m = epm_pkg::EPM_PROG_ENC;
               5'h1F: m = epm_pkg::EPM_LOCK_ONE;
               5'h1C: m = epm_pkg::EPM_LOCK_TWO;
               5'h16: m = epm_pkg::EPM_LOCK_THR;
               default: m = epm_pkg::EPM_IDLE;
            endcase
         end else if (p[`EPM_P_EA] && p[`EPM_P_STROBE]) begin
            unique case (ms)
               5'h03: m = epm_pkg::EPM_VERIFY;
               5'h00: m = epm_pkg::EPM_SIGNATURE;
               default: m = epm_pkg::EPM_IDLE;
            endcase
         end
      end
      return m;
   endfunction

   logic [ADDR_W-1:0] pin_addr;
   logic [7:0]        pin_data;
   logic              strobe_fall;
   logic              enabled;
   logic              addr_phase;
   logic [7:0]        sig_byte;

   // Address on two ports, data on port zero
   assign pin_addr    = s.sync2[`EPM_P_ADDR_HI:`EPM_P_ADDR_LO];
   assign pin_data    = s.sync2[`EPM_P_DATA_HI:0];
   assign enabled     = s.ctrl[`EPM_CTRL_ENABLE_BIT];
   assign strobe_fall = s.strobe_prev && !s.sync2[`EPM_P_STROBE];
   assign addr_phase  = hsel && htrans[1] && hready;

   // Signature bytes at fixed addresses
   always_comb begin
      unique case (pin_addr)
         `EPM_SIG_ADDR0: sig_byte = SIG0;
         `EPM_SIG_ADDR1: sig_byte = SIG1;
         `EPM_SIG_ADDR2: sig_byte = SIG2;
         default:        sig_byte = `EPM_ERASED;
      endcase
   end

   // Memory access from synchronised pins
   always_comb begin
      code_if.addr  = pin_addr;
      code_if.wdata = pin_data;
      code_if.we    = enabled && strobe_fall && (s.mode == epm_pkg::EPM_PROG_CODE) && !s.lock[0];
      enc_if.addr   = pin_addr[`EPM_ENC_W-1:0];
      enc_if.wdata  = pin_data;
      enc_if.we     = enabled && strobe_fall && (s.mode == epm_pkg::EPM_PROG_ENC) && !s.lock[0]
                      && (pin_addr < `EPM_ENC_LIMIT);
   end

   always_comb begin
      next_s             = s;
      next_s.sync1       = {reset_pin, fetch_strobe_n, latch_pulse_program_strobe, prog_voltage_high,
                            ext_access_high, mode_select_a, mode_select_b, mode_select_c, mode_select_d,
                            mode_select_e, high_address_pins, low_address_pins, code_byte_pins_in};
      next_s.sync2       = s.sync1;
      next_s.strobe_prev = s.sync2[`EPM_P_STROBE];
      next_s.mode        = decode_mode(s.sync2);

      // Strobe pulses count and lock programming
      if (enabled && strobe_fall) begin
         unique case (s.mode)
            epm_pkg::EPM_PROG_CODE,
            epm_pkg::EPM_PROG_ENC:  next_s.prog_count = s.prog_count + 16'h0001;
            epm_pkg::EPM_LOCK_ONE:  next_s.lock[0] = 1'b1;
            epm_pkg::EPM_LOCK_TWO:  next_s.lock[1] = 1'b1;
            epm_pkg::EPM_LOCK_THR:  next_s.lock[2] = 1'b1;
            default:                next_s.lock = s.lock;
         endcase
      end

      // Output drive in verify and signature modes
      next_s.dout_oe = enabled && ((s.mode == epm_pkg::EPM_VERIFY) || (s.mode == epm_pkg::EPM_SIGNATURE));
      if (s.mode == epm_pkg::EPM_SIGNATURE) begin
         next_s.dout = sig_byte;
      end else if (s.lock[1]) begin
         next_s.dout = `EPM_ERASED;
      end else begin
         next_s.dout = code_if.rdata ~^ enc_if.rdata;
      end

      // Register writes, data phase
      next_s.wr_pend = addr_phase && hwrite;
      next_s.wr_addr = haddr[7:0];
      if (s.wr_pend && (s.wr_addr == `EPM_CTRL_OFS)) begin
         next_s.ctrl[`EPM_CTRL_ENABLE_BIT] = hwdata[`EPM_CTRL_ENABLE_BIT];
         if (hwdata[`EPM_CTRL_ERASE_BIT] && !(enabled && strobe_fall)) begin
            next_s.lock = 3'h0;
         end
      end

      // Register reads, registered in the address phase
      next_s.hrdata = 32'h0000_0000;
      if (addr_phase && !hwrite) begin
         unique case (haddr[7:0])
            `EPM_CTRL_OFS:   next_s.hrdata = {30'h0000_0000, s.ctrl};
            `EPM_STATUS_OFS: next_s.hrdata = {s.prog_count, 5'h00, s.lock, s.mode};
            default:         next_s.hrdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s             <= '0;
         s.mode        <= epm_pkg::EPM_IDLE;
         s.ctrl        <= `EPM_CTRL_RESET;
         s.dout        <= `EPM_ERASED;
      end else begin
         s <= next_s;
      end
   end

   assign hreadyout          = 1'b1;
   assign hresp              = 1'b0;
   assign hrdata             = s.hrdata;
   assign code_byte_pins_out = s.dout;
   assign code_byte_pins_oe  = s.dout_oe;
endmodule // epm_port

// *** src/epm_consts.svh ***
// Purpose: Offsets, field positions, reset values and constants of the EPROM program port
// Assumes: AHB-Lite register access, 25 MHz hclk
// Notes:   Overview of the pin-level programming behaviour follows
//
// Overview of operation
// - Program code byte: vpp, a low, others high
// - Verify: strobe high, a b c low
// - Encryption programming, addresses 0-3FH, d low
// - Lock bits chosen by mode select b..e
// - Signature read: all mode selects low
// - Address low byte port one, high six
// - Code byte in when programming, out in verify and signature reads only
// - Verify output is code XNOR encryption byte, or FFH once the second lock bit is set
// - Signature bytes at 30H, 31H and 60H
`ifndef EPM_CONSTS_SVH
`define EPM_CONSTS_SVH

// Register byte offsets, control reset value and control bit positions
`define EPM_CTRL_OFS        8'h00
`define EPM_STATUS_OFS      8'h04
`define EPM_CTRL_RESET      2'h1
`define EPM_CTRL_ENABLE_BIT 0
`define EPM_CTRL_ERASE_BIT  1

// Synchronised pin vector layout
`define EPM_PIN_W     32
`define EPM_P_RST     31
`define EPM_P_FETCH   30
`define EPM_P_STROBE  29
`define EPM_P_VPP     28
`define EPM_P_EA      27
`define EPM_P_MSA     26
`define EPM_P_MSB     25
`define EPM_P_MSC     24
`define EPM_P_MSD     23
`define EPM_P_MSE     22
`define EPM_P_ADDR_HI 21
`define EPM_P_ADDR_LO 8
`define EPM_P_DATA_HI 7

// Memory geometry and fixed contents
`define EPM_ADDR_W    14
`define EPM_ENC_W     6
`define EPM_ENC_LIMIT 14'h0040
`define EPM_ERASED    8'hFF
`define EPM_SIG_ADDR0 14'h0030
`define EPM_SIG_ADDR1 14'h0031
`define EPM_SIG_ADDR2 14'h0060

`endif

// *** src/epm_pkg.sv ***
// Purpose: Types of the EPROM program port
// Assumes: Constants come from epm_consts.svh
// Notes:   Modes are one-hot
`include "epm_consts.svh"
package epm_pkg;

   typedef enum logic [7:0] {
      EPM_IDLE      = 8'h01,
      EPM_PROG_CODE = 8'h02,
      EPM_VERIFY    = 8'h04,
      EPM_PROG_ENC  = 8'h08,
      EPM_LOCK_ONE  = 8'h10,
      EPM_LOCK_TWO  = 8'h20,
      EPM_LOCK_THR  = 8'h40,
      EPM_SIGNATURE = 8'h80
   } epm_mode_type;

   typedef struct packed {
      logic [`EPM_PIN_W-1:0] sync1;
      logic [`EPM_PIN_W-1:0] sync2;
      logic                  strobe_prev;
      epm_mode_type          mode;
      logic [2:0]            lock;
      logic [15:0]           prog_count;
      logic [7:0]            dout;
      logic                  dout_oe;
      logic [1:0]            ctrl;
      logic                  wr_pend;
      logic [7:0]            wr_addr;
      logic [31:0]           hrdata;
   } epm_state_type;

endpackage

// *** src/epm_mem_if.sv ***
// Purpose: Carrier between the port logic and a byte memory
// Assumes: One writer, registered read
// Notes:   Address width is a parameter
`timescale 1ns/10ps
interface epm_mem_if #(parameter int AW = 14);
   logic [AW-1:0] addr;
   logic [7:0]    wdata;
   logic          we;
   logic [7:0]    rdata;
   modport ctrl (output addr, output wdata, output we, input rdata);
   modport mem  (input addr, input wdata, input we, output rdata);
endinterface

// *** src/epm_mem.sv ***
// Purpose: Byte memory with registered read data
// Assumes: Single clock, write and read in one port
// Notes:   Contents start erased to all ones
`timescale 1ns/10ps
`include "epm_consts.svh"
module epm_mem #(
   parameter int AW = 14
) (
   // Clock
   input wire logic hclk,
   // Access
   epm_mem_if.mem   port
);
   logic [7:0] store [0:(1<<AW)-1];
   logic [7:0] rdata_q;

   initial begin
      for (int i = 0; i < (1 << AW); i++) begin
         store[i] = `EPM_ERASED;
      end
   end

   // Plain always: the array is also given its erased contents at time zero
   always @(posedge hclk) begin
      if (port.we) begin
         store[port.addr] <= port.wdata;
      end
   end

   always_ff @(posedge hclk) begin
      rdata_q <= store[port.addr];
   end

   assign port.rdata = rdata_q;
endmodule // epm_mem

// *** sim/epm_port_properties.sv ***
// Purpose: Assertions on the ports of the EPROM program port
// Assumes: Programmer holds pin levels for several cycles
// Notes:   Bound to epm_port
`timescale 1ns/10ps
module epm_port_properties #(parameter bit [7:0] SIG0 = 8'h00, SIG1 = 8'h00, SIG2 = 8'h00) (
   // Bus
   input wire logic        hclk, hresetn, hsel, hready, hreadyout, hresp,
   input wire logic [1:0]  htrans,
   input wire logic [31:0] hrdata,
   // Pins
   input wire logic        reset_pin, fetch_strobe_n, latch_pulse_program_strobe, prog_voltage_high,
   input wire logic        ext_access_high, mode_select_a, mode_select_b, mode_select_c,
   input wire logic        mode_select_d, mode_select_e, code_byte_pins_oe,
   input wire logic [5:0]  high_address_pins,
   input wire logic [7:0]  low_address_pins, code_byte_pins_out
);
   wire [13:0] adr = {high_address_pins, low_address_pins};
   wire [4:0]  ms  = {mode_select_a, mode_select_b, mode_select_c, mode_select_d, mode_select_e};
   wire        rlv = reset_pin && !fetch_strobe_n && latch_pulse_program_strobe && ext_access_high;
   wire        vfy = rlv && !prog_voltage_high && ms == 5'b00011;
   wire        sig = rlv && !prog_voltage_high && ms == 5'b00000;
   wire [7:0]  sv  = adr == 14'h0030 ? SIG0 : adr == 14'h0031 ? SIG1 : adr == 14'h0060 ? SIG2 : 8'hFF;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_vfy; vfy [*7] |=> code_byte_pins_oe; endproperty
   property p_sig; (sig && $stable(adr)) [*7] |=> code_byte_pins_oe && code_byte_pins_out == sv; endproperty
   property p_idle; !(vfy || sig) [*6] |=> !code_byte_pins_oe; endproperty
   property p_rise; $rose(code_byte_pins_oe) |-> $past(vfy || sig, 2); endproperty
   property p_hold; (vfy && $stable(adr)) [*8] |=> $stable(code_byte_pins_out); endproperty
   property p_prog; prog_voltage_high [*6] |=> !code_byte_pins_oe; endproperty
   property p_okay; hreadyout && !hresp; endproperty
   property p_rdz; !(hsel && htrans[1] && hready) |=> hrdata == 32'h0; endproperty
   a_vfy: assert property (p_vfy) else $error("verify levels not driven");
   a_sig: assert property (p_sig) else $error("signature byte wrong");
   a_idle: assert property (p_idle) else $error("driving outside read modes");
   a_rise: assert property (p_rise) else $error("drive began without read levels");
   a_hold: assert property (p_hold) else $error("output moved with address held");
   a_prog: assert property (p_prog) else $error("driving while programming");
   a_okay: assert property (p_okay) else $error("bus not ready or error");
   a_rdz: assert property (p_rdz) else $error("read data outside data phase");
   c_vfy: cover property (vfy && code_byte_pins_oe);
   c_sig: cover property (sig && code_byte_pins_oe);
   c_prg: cover property (prog_voltage_high && $fell(latch_pulse_program_strobe));
endmodule // epm_port_properties
bind epm_port epm_port_properties #(.SIG0(SIG0), .SIG1(SIG1), .SIG2(SIG2)) epm_port_properties_inst (
   .hclk, .hresetn, .hsel, .hready, .hreadyout, .hresp, .htrans, .hrdata, .reset_pin, .fetch_strobe_n,
   .latch_pulse_program_strobe, .prog_voltage_high, .ext_access_high, .mode_select_a, .mode_select_b,
   .mode_select_c, .mode_select_d, .mode_select_e, .code_byte_pins_oe, .high_address_pins,
   .low_address_pins, .code_byte_pins_out);

// *** sim/epm_prog_model.sv ***
// Purpose: Behavioural programmer on the EPROM port pins
// Assumes: Called just after a rising hclk edge
// Notes:   Strobe pulse shortened to PULSE_CYC cycles
`timescale 1ns/10ps
module epm_prog_model #(
   parameter int PULSE_CYC = 4
) (
   // Clock
   input  wire logic       hclk,
   // Towards the port
   output logic [9:0]      ctl,
   output logic [13:0]     adr,
   output logic [7:0]      line,
   // From the port
   input  wire logic [7:0] dout,
   input  wire logic       oe
);
   logic [7:0] dat = 8'h00;
   logic       drv = 1'b0;
   // Released data lines float up to the pull-ups
   assign line = oe ? dout : (drv ? dat : 8'hFF);
   initial begin
      ctl = 10'h080;
      adr = 14'h0000;
   end
   task automatic apply(input logic [9:0] c, input logic [13:0] a, input logic [7:0] d, input logic dr);
      ctl <= c;
      adr <= a;
      dat <= d;
      drv <= dr;
      repeat (6) @(posedge hclk);
   endtask
   task automatic pulse(input int n);
      repeat (n) begin
         ctl[7] <= 1'b0;
         repeat (PULSE_CYC) @(posedge hclk);
         ctl[7] <= 1'b1;
         repeat (PULSE_CYC) @(posedge hclk);
      end
   endtask
endmodule // epm_prog_model

// *** sim/epm_port_test.sv ***
// Purpose: Self-checking bench of the EPROM program port
// Assumes: Programmer model on the pins, AHB-Lite master here
// Notes:   Bench model tracks code, encryption bytes, locks and strobe count
`timescale 1ns/10ps
`include "epm_consts.svh"
module epm_port_test;
   localparam logic [7:0] S0 = 8'h5A, S1 = 8'hC3, S2 = 8'h96; // Arbitrary identification values
   localparam logic [9:0] C_CODE = 10'h2CF, C_VFY = 10'h2A3, C_ENC = 10'h2CD, C_LK1 = 10'h2DF;
   localparam logic [9:0] C_LK2 = 10'h2DC, C_LK3 = 10'h2D6, C_SIG = 10'h2A0, C_IDLE = 10'h080;
   localparam logic [31:0] A_CTL = {24'h0, `EPM_CTRL_OFS}, A_ST = {24'h0, `EPM_STATUS_OFS};
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, oe;
   logic [1:0]  htrans = 2'b00;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, seed = 32'h351A;
   logic [9:0]  ctl;
   logic [13:0] adr, a0;
   logic [7:0]  line, dout;
   logic [7:0]  code [0:16383];
   logic [7:0]  enc [0:63];
   logic [13:0] sa [4] = '{14'h0030, 14'h0031, 14'h0060, 14'h0032};
   logic [7:0]  se [4] = '{S0, S1, S2, 8'hFF};
   logic [2:0]  locks = 3'b000;
   logic        en = 1'b1;
   int          cnt = 0, n_mismatch = 0, cmp_count = 0;
   always #20 hclk = ~hclk;
   epm_port #(.SIG0(S0), .SIG1(S1), .SIG2(S2)) epm_port_inst (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout),
      .hreadyout, .hrdata, .hresp, .reset_pin(ctl[9]), .fetch_strobe_n(ctl[8]),
      .latch_pulse_program_strobe(ctl[7]), .prog_voltage_high(ctl[6]), .ext_access_high(ctl[5]),
      .mode_select_a(ctl[4]), .mode_select_b(ctl[3]), .mode_select_c(ctl[2]), .mode_select_d(ctl[1]),
      .mode_select_e(ctl[0]), .low_address_pins(adr[7:0]), .high_address_pins(adr[13:8]),
      .code_byte_pins_in(line), .code_byte_pins_out(dout), .code_byte_pins_oe(oe));
   epm_prog_model pm (.hclk, .ctl, .adr, .line, .dout, .oe);
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
      int n;
      logic r;
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      for (int p = 0; p < 2; p++) begin
         n = 0;
         do begin
            @(posedge hclk);
            r = hreadyout;
            rd = hrdata;
            n++;
         end while (r !== 1'b1 && n < 50);
         if (r !== 1'b1) begin
            n_mismatch++;
            wrap_up();
         end
         if (p == 0) begin
            hsel <= 1'b0;
            htrans <= 2'b00;
            hwdata <= wd;
         end
      end
   endtask
   task automatic rd_pin(input logic [9:0] c, input logic [13:0] a, input logic [8:0] e);
      int n;
      pm.apply(c, a, 8'h00, 1'b0);
      n = 0;
      while (oe !== 1'b1 && n < 10) begin
         @(posedge hclk);
         n++;
      end
      @(negedge hclk);
      chk("data_lines", {23'h0, e}, {23'h0, oe, line});
      @(posedge hclk);
   endtask
   task automatic vfy(input logic [13:0] a);
      rd_pin(C_VFY, a, {1'b1, locks[1] ? 8'hFF : ~(code[a] ^ enc[a[5:0]])});
   endtask
   task automatic step(input logic [9:0] c, input logic [13:0] a, input logic [7:0] d);
      pm.apply(c, a, d, 1'b1);
      pm.pulse(25);
      pm.apply(C_IDLE, a, d, 1'b0);
      if (en && !locks[0] && c == C_CODE) code[a] = d;
      if (en && !locks[0] && c == C_ENC && a < 14'h0040) enc[a[5:0]] = d;
      if (en && (c == C_CODE || c == C_ENC)) cnt += 25;
      if (en) locks |= {c == C_LK3, c == C_LK2, c == C_LK1};
   endtask
   task automatic st();
      bus(1'b0, A_ST, 32'h0);
      chk("status", {cnt[15:0], 5'h0, locks, 8'(epm_pkg::EPM_IDLE)}, rd);
   endtask
   initial begin
      foreach (code[i]) code[i] = 8'hFF;
      foreach (enc[i]) enc[i] = 8'hFF;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, A_CTL, 32'h0);
      chk("ctrl", 32'h1, rd);
      bus(1'b0, 32'h8, 32'h0);
      chk("unmapped", 32'h0, rd);
      for (int i = 0; i < 3; i++) begin
         void'(xs());
         step(C_CODE, seed[13:0], seed[21:14]);
         vfy(seed[13:0]);
      end
      a0 = seed[13:0];
      bus(1'b0, A_ST, 32'h0);
      chk("count", {cnt[15:0], 16'h0}, {rd[31:16], 16'h0});
      void'(xs());
      step(C_ENC, 14'h0005, seed[7:0]);
      step(C_ENC, 14'h0045, ~seed[7:0]);
      vfy(14'h0005);
      vfy(14'h0045);
      foreach (sa[i]) rd_pin(C_SIG, sa[i], {1'b1, se[i]});
      rd_pin(10'h2B3, a0, 9'h0FF);
      bus(1'b1, A_CTL, 32'h0);
      en = 1'b0;
      step(C_CODE, a0, ~code[a0]);
      bus(1'b1, A_CTL, 32'h1);
      en = 1'b1;
      vfy(a0);
      step(C_LK1, a0, 8'h00);
      step(C_CODE, a0, 8'h00);
      vfy(a0);
      step(C_LK2, a0, 8'h00);
      vfy(a0);
      step(C_LK3, a0, 8'h00);
      st();
      bus(1'b1, A_CTL, 32'h3);
      locks = 3'b000;
      st();
      bus(1'b0, A_CTL, 32'h0);
      chk("ctrl", 32'h1, rd);
      wrap_up();
   end
endmodule // epm_port_test
